// ---- hw/lbr_pkg.sv ----
package lbr_pkg;

    // ------------------------------------------------------------------
    // timing base
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned TICK_NS     = 1000;
    // cycles per 1 us measurement tick
    localparam int unsigned TICK_CYC    = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
    localparam int unsigned WIDTH_W     = 12;

    // ------------------------------------------------------------------
    // classification windows, in us (one tick each)
    // ------------------------------------------------------------------
    localparam logic [11:0] MIN_HALF_US     = 12'h064; // 100 us
    localparam logic [11:0] MAX_HALF1_US    = 12'h271; // 625 us
    localparam logic [11:0] MAX_HALF2_US    = 12'h244; // 580 us
    localparam logic [11:0] MAX_DOUBLE2_US  = 12'h44C; // 1100 us
    localparam logic [11:0] STOP_US         = 12'h76C; // 1900 us
    localparam logic [11:0] WIDTH_SAT       = 12'hFFF;

    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam int unsigned DATA_BITS   = 16;
    localparam logic [4:0]  DATA_BITS_C = 5'h10;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LBR_CLS_VIOL   = 2'b00,
        LBR_CLS_HALF   = 2'b01,
        LBR_CLS_DOUBLE = 2'b10,
        LBR_CLS_STOP   = 2'b11
    } lbr_cls_type;

    typedef enum logic [1:0] {
        LBR_ST_WAIT_STOP = 2'b00,
        LBR_ST_IDLE      = 2'b01,
        LBR_ST_FIRST     = 2'b10,
        LBR_ST_SECOND    = 2'b11
    } lbr_state_type;

    typedef struct packed {
        logic        valid;
        logic        second;
        lbr_cls_type cls;
        logic [11:0] width;
    } lbr_meas_type;

    typedef struct packed {
        logic        done;
        logic        size_err;
        logic        timing_err;
        logic [15:0] data;
    } lbr_frame_type;

    localparam lbr_meas_type  MEAS_RST  = '0;
    localparam lbr_frame_type FRAME_RST = '0;

endpackage

// ---- hw/lbr_tick_gen.sv ----
`timescale 1ns/1ps
module lbr_tick_gen #(
    parameter int unsigned DIV = 20
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // one-cycle tick every DIV clocks
    output logic      tick_o
);

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] div_cnt_ff;
    logic          tick_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_cnt_ff <= '0;
            tick_ff    <= 1'b0;
        end else if (div_cnt_ff == LAST) begin
            div_cnt_ff <= '0;
            tick_ff    <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + CW'(1);
            tick_ff    <= 1'b0;
        end
    end

    assign tick_o = tick_ff;

endmodule // lbr_tick_gen

// ---- hw/lbr_rx_timing.sv ----
// Behaviour
// - each logical bit splits into first and second sections, measured apart.
// - width is time between consecutive edges of either polarity.
// - first section: under 100us violation, 100..625us half bit.
// - first section: over 625us under 1900us violation, 1900us or more stop.
// - second: under 100us violation, to 580us half, to 1100us double half.
// - second: over 1100us under 1900us violation, 1900us or more stop.
// - stop condition found by a separate interval timer, not edge measure.
// - stop condition when line stays high for 1900us.
// - stop timer starts on each rising edge, stops on each falling edge.
// - stop only when timer expires with no falling edge since last rise.
// - last bit one merges with stop; decode it when stop is detected.
// - on every edge event, start stop timer if line is high.
// - each captured width is handed to the frame bit stage.
// - second-section event: low gives one, high gives zero, stop gives one.
// - start bit not stored; exactly 16 data bits, else size error.
// - on stop: finish frame, signal completion, halt stop timer.
`timescale 1ns/1ps
module lbr_rx_timing #(
    parameter int unsigned TICK_CYC = lbr_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // receive line pin, asynchronous
    input  wire logic                  rx_line_i,
    // per-edge measurement result
    output lbr_pkg::lbr_meas_type      meas_o,
    // frame result
    output lbr_pkg::lbr_frame_type     frame_o,
    // status
    output logic                       busy_o,
    output logic                       stop_run_o
);

    // ------------------------------------------------------------------
    // classification
    // ------------------------------------------------------------------
    function automatic lbr_pkg::lbr_cls_type classify(
        input logic [11:0] w,
        input logic        second
    );
        lbr_pkg::lbr_cls_type c;
        c = lbr_pkg::LBR_CLS_VIOL;
        if (w < lbr_pkg::MIN_HALF_US) begin
            c = lbr_pkg::LBR_CLS_VIOL;
        end else if (w >= lbr_pkg::STOP_US) begin
            c = lbr_pkg::LBR_CLS_STOP;
        end else if (!second) begin
            if (w <= lbr_pkg::MAX_HALF1_US) begin
                c = lbr_pkg::LBR_CLS_HALF;
            end else begin
                c = lbr_pkg::LBR_CLS_VIOL;
            end
        end else begin
            if (w <= lbr_pkg::MAX_HALF2_US) begin
                c = lbr_pkg::LBR_CLS_HALF;
            end else if (w <= lbr_pkg::MAX_DOUBLE2_US) begin
                c = lbr_pkg::LBR_CLS_DOUBLE;
            end else begin
                c = lbr_pkg::LBR_CLS_VIOL;
            end
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // tick base
    // ------------------------------------------------------------------
    logic tick;

    lbr_tick_gen #(
        .DIV    (TICK_CYC)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst    (rst),
        .tick_o (tick)
    );

    // ------------------------------------------------------------------
    // line synchroniser and edge detect
    // ------------------------------------------------------------------
    logic sync_meta_ff;
    logic sync_line_ff;
    logic line_prev_ff;
    logic edge_any;
    logic edge_rise;
    logic edge_fall;

    // reset to idle-high so a quiet bus shows no false edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_meta_ff <= 1'b1;
            sync_line_ff <= 1'b1;
            line_prev_ff <= 1'b1;
        end else begin
            sync_meta_ff <= rx_line_i;
            sync_line_ff <= sync_meta_ff;
            line_prev_ff <= sync_line_ff;
        end
    end

    assign edge_any  = sync_line_ff ^ line_prev_ff;
    assign edge_rise = edge_any & sync_line_ff;
    assign edge_fall = edge_any & ~sync_line_ff;

    // ------------------------------------------------------------------
    // edge interval counter
    // ------------------------------------------------------------------
    logic [11:0] width_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            width_ff <= '0;
        end else if (edge_any) begin
            // the edge cycle's own tick counts, else each width loses one
            width_ff <= tick ? 12'h001 : 12'h000;
        end else if (tick && width_ff != lbr_pkg::WIDTH_SAT) begin
            width_ff <= width_ff + 12'h001;
        end
    end

    // ------------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------------
    lbr_pkg::lbr_state_type state_ff;
    lbr_pkg::lbr_cls_type   cls_now;
    logic                   in_second;
    logic                   stop_run_ff;
    logic [11:0]            stop_cnt_ff;
    logic                   stop_hit;

    assign in_second = (state_ff == lbr_pkg::LBR_ST_SECOND);
    assign cls_now   = classify(width_ff, in_second);

    // ------------------------------------------------------------------
    // stop condition interval timer
    // ------------------------------------------------------------------
    // an edge in the expiry cycle wins, so a late fall still cancels
    // one tick of margin: the first tick may come right after the start
    assign stop_hit = stop_run_ff && tick && !edge_any
                    && (stop_cnt_ff == lbr_pkg::STOP_US);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stop_run_ff <= 1'b0;
            stop_cnt_ff <= '0;
        end else if (edge_fall) begin
            stop_run_ff <= 1'b0;
            stop_cnt_ff <= '0;
        end else if (edge_rise) begin
            stop_run_ff <= 1'b1;
            stop_cnt_ff <= '0;
        end else if (stop_hit) begin
            stop_run_ff <= 1'b0;
            stop_cnt_ff <= '0;
        end else if (state_ff == lbr_pkg::LBR_ST_WAIT_STOP
                     && sync_line_ff && !stop_run_ff) begin
            // bus already high at reset or after an error
            stop_run_ff <= 1'b1;
            stop_cnt_ff <= '0;
        end else if (stop_run_ff && tick) begin
            stop_cnt_ff <= stop_cnt_ff + 12'h001;
        end
    end

    // ------------------------------------------------------------------
    // measurement output
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meas_o <= lbr_pkg::MEAS_RST;
        end else begin
            meas_o.valid  <= edge_any;
            meas_o.second <= in_second;
            meas_o.cls    <= cls_now;
            meas_o.width  <= width_ff;
        end
    end

    // ------------------------------------------------------------------
    // bit decode helpers
    // ------------------------------------------------------------------
    logic        start_pend_ff;
    logic [4:0]  bit_cnt_ff;
    logic        ovf_ff;
    logic [15:0] shreg_ff;
    logic        edge_dec;
    logic        stop_dec;
    logic        do_dec;
    logic        dec_bit;
    logic        store;
    logic        store_ovf;
    logic [15:0] nxt_shreg;
    logic [4:0]  nxt_cnt;
    logic        nxt_ovf;
    logic        violation;

    always_comb begin
        edge_dec  = edge_any && in_second
                 && (cls_now == lbr_pkg::LBR_CLS_HALF
                  || cls_now == lbr_pkg::LBR_CLS_DOUBLE);
        stop_dec  = stop_hit && in_second;
        do_dec    = edge_dec || stop_dec;
        // line low after the event means one; stop always means one
        dec_bit   = stop_dec ? 1'b1 : ~sync_line_ff;
        store     = do_dec && !start_pend_ff;
        store_ovf = store && (bit_cnt_ff == lbr_pkg::DATA_BITS_C);
        nxt_shreg = shreg_ff;
        nxt_cnt   = bit_cnt_ff;
        nxt_ovf   = ovf_ff;
        if (store_ovf) begin
            nxt_ovf = 1'b1;
        end else if (store) begin
            nxt_shreg = {shreg_ff[14:0], dec_bit};
            nxt_cnt   = bit_cnt_ff + 5'h01;
        end
        violation = 1'b0;
        if (edge_any && state_ff == lbr_pkg::LBR_ST_FIRST) begin
            violation = (cls_now != lbr_pkg::LBR_CLS_HALF);
        end else if (edge_any && in_second) begin
            violation = !edge_dec;
        end
    end

    // ------------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= lbr_pkg::LBR_ST_WAIT_STOP;
        end else if (violation) begin
            state_ff <= lbr_pkg::LBR_ST_WAIT_STOP;
        end else begin
            unique case (state_ff)
                lbr_pkg::LBR_ST_WAIT_STOP: begin
                    if (stop_hit) begin
                        state_ff <= lbr_pkg::LBR_ST_IDLE;
                    end
                end
                lbr_pkg::LBR_ST_IDLE: begin
                    if (edge_fall) begin
                        state_ff <= lbr_pkg::LBR_ST_FIRST;
                    end
                end
                lbr_pkg::LBR_ST_FIRST: begin
                    if (edge_any) begin
                        state_ff <= lbr_pkg::LBR_ST_SECOND;
                    end else if (stop_hit) begin
                        state_ff <= lbr_pkg::LBR_ST_IDLE;
                    end
                end
                lbr_pkg::LBR_ST_SECOND: begin
                    if (edge_any
                        && cls_now == lbr_pkg::LBR_CLS_HALF) begin
                        state_ff <= lbr_pkg::LBR_ST_FIRST;
                    end else if (stop_hit) begin
                        state_ff <= lbr_pkg::LBR_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // data accumulation
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_pend_ff <= 1'b0;
            bit_cnt_ff    <= '0;
            ovf_ff        <= 1'b0;
            shreg_ff      <= '0;
        end else if (state_ff == lbr_pkg::LBR_ST_IDLE && edge_fall) begin
            start_pend_ff <= 1'b1;
            bit_cnt_ff    <= '0;
            ovf_ff        <= 1'b0;
            shreg_ff      <= '0;
        end else begin
            if (do_dec) begin
                start_pend_ff <= 1'b0;
            end
            bit_cnt_ff <= nxt_cnt;
            ovf_ff     <= nxt_ovf;
            shreg_ff   <= nxt_shreg;
        end
    end

    // ------------------------------------------------------------------
    // frame result
    // ------------------------------------------------------------------
    logic frame_end;

    assign frame_end = stop_hit && !violation
                    && (state_ff == lbr_pkg::LBR_ST_FIRST || in_second);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_o <= lbr_pkg::FRAME_RST;
        end else begin
            frame_o.done       <= frame_end;
            frame_o.timing_err <= violation && state_ff
                                  != lbr_pkg::LBR_ST_WAIT_STOP;
            frame_o.size_err   <= frame_end
                                  && (nxt_ovf || nxt_cnt
                                      != lbr_pkg::DATA_BITS_C);
            if (frame_end) begin
                frame_o.data <= nxt_shreg;
            end
        end
    end

    // ------------------------------------------------------------------
    // status
    // ------------------------------------------------------------------
    assign busy_o     = (state_ff == lbr_pkg::LBR_ST_FIRST) || in_second;
    assign stop_run_o = stop_run_ff;

endmodule // lbr_rx_timing

// ---- test/lbr_rx_timing_checker.sv ----
`timescale 1ns/1ps
module lbr_rx_timing_checker #(
    parameter int unsigned TICK_CYC = 20
) (
    // watched ports of the receiver
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   rx_line_i,
    input wire lbr_pkg::lbr_meas_type  meas_o,
    input wire lbr_pkg::lbr_frame_type frame_o,
    input wire logic                   busy_o,
    input wire logic                   stop_run_o
);
    localparam int STOP_CYC = int'(lbr_pkg::STOP_US) * int'(TICK_CYC);
    // sync delay and tick phase allowance
    localparam int RUN_MAX  = STOP_CYC + 2 * int'(TICK_CYC) + 4;

    logic [15:0] hi_cnt_ff;
    logic [15:0] run_cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (rst || !rx_line_i)
            hi_cnt_ff <= '0;
        else if (hi_cnt_ff != 16'hFFFF)
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !stop_run_o)
            run_cnt_ff <= '0;
        else if (run_cnt_ff != 16'hFFFF)
            run_cnt_ff <= run_cnt_ff + 16'h0001;
    end

    function automatic logic [1:0] cls1(input logic [11:0] w);
        if (w < 12'h064) return 2'b00;
        if (w <= 12'h271) return 2'b01;
        if (w < 12'h76C) return 2'b00;
        return 2'b11;
    endfunction

    function automatic logic [1:0] cls2(input logic [11:0] w);
        if (w < 12'h064) return 2'b00;
        if (w <= 12'h244) return 2'b01;
        if (w <= 12'h44C) return 2'b10;
        if (w < 12'h76C) return 2'b00;
        return 2'b11;
    endfunction

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_edge_meas;
        $changed(rx_line_i) |-> ##[2:4] meas_o.valid;
    endproperty
    a_edge_meas: assert property (p_edge_meas)
        else $error("no measurement after line edge");
    property p_first_cls;
        meas_o.valid && !meas_o.second |-> meas_o.cls == cls1(meas_o.width);
    endproperty
    a_first_cls: assert property (p_first_cls)
        else $error("wrong first section class");
    property p_second_cls;
        meas_o.valid && meas_o.second |-> meas_o.cls == cls2(meas_o.width);
    endproperty
    a_second_cls: assert property (p_second_cls)
        else $error("wrong second section class");
    property p_rise_start;
        $rose(rx_line_i) |-> ##[2:4] stop_run_o;
    endproperty
    a_rise_start: assert property (p_rise_start)
        else $error("stop timer not started on rise");
    property p_fall_stop;
        $fell(rx_line_i) |-> ##[2:4] !stop_run_o;
    endproperty
    a_fall_stop: assert property (p_fall_stop)
        else $error("stop timer not stopped on fall");
    property p_done_high;
        frame_o.done |-> int'(hi_cnt_ff) >= STOP_CYC;
    endproperty
    a_done_high: assert property (p_done_high)
        else $error("frame done before line high long enough");
    property p_run_bound;
        int'(run_cnt_ff) <= RUN_MAX;
    endproperty
    a_run_bound: assert property (p_run_bound)
        else $error("stop timer ran past its interval");
    property p_done_halt;
        frame_o.done |-> ##[0:1] !stop_run_o;
    endproperty
    a_done_halt: assert property (p_done_halt)
        else $error("stop timer left running after done");
    property p_size_done;
        frame_o.size_err |-> frame_o.done;
    endproperty
    a_size_done: assert property (p_size_done)
        else $error("size error without done");
    property p_viol_err;
        meas_o.valid && meas_o.cls == lbr_pkg::LBR_CLS_VIOL && $past(busy_o)
            |-> ##[0:2] frame_o.timing_err;
    endproperty
    a_viol_err: assert property (p_viol_err)
        else $error("violation in frame without error");

    c_frame_ok: cover property (frame_o.done && !frame_o.size_err);
    c_size: cover property (frame_o.size_err);
    c_terr: cover property (frame_o.timing_err);
    c_double: cover property (meas_o.valid && meas_o.cls == 2'b10);
endmodule // lbr_rx_timing_checker

bind lbr_rx_timing lbr_rx_timing_checker #(.TICK_CYC(TICK_CYC)) chk_u (
    .clk_sys(clk_sys), .rst(rst), .rx_line_i(rx_line_i), .meas_o(meas_o),
    .frame_o(frame_o), .busy_o(busy_o), .stop_run_o(stop_run_o)
);

// ---- test/lbr_bus_ctrl_model.sv ----
`timescale 1ns/1ps
module lbr_bus_ctrl_model #(
    parameter int TICK_CYC = 20
) (
    // clock and line
    input  wire logic clk_sys,
    output logic      rx_line
);
    // line idles high, as the bus pull-up leaves it
    initial rx_line = 1'b1;

    task automatic level(input logic lvl, input int ticks);
        rx_line = lvl;
        repeat (ticks * TICK_CYC) @(posedge clk_sys);
        #1;
    endtask

    // one is low then high, zero high then low; equal halves merge
    task automatic send_frame(input logic [31:0] bits, input int n, half);
        level(1'b0, half);
        level(1'b1, half);
        for (int i = n - 1; i >= 0; i--) begin
            level(~bits[i], half);
            level(bits[i], half);
        end
        rx_line = 1'b1;
    endtask
endmodule // lbr_bus_ctrl_model

// ---- test/lbr_rx_timing_test.sv ----
`timescale 1ns/1ps
module lbr_rx_timing_test;
    // ------------------------------------------------------------
    // setup
    // ------------------------------------------------------------
    localparam int TCK  = 2;   // short tick keeps the run brief
    localparam int HALF = 300; // its double still lands above 580
    logic                   clk_sys;
    logic                   rst;
    logic                   rx_line;
    lbr_pkg::lbr_meas_type  meas;
    lbr_pkg::lbr_frame_type frm;
    logic                   busy;
    logic                   stop_run;
    lbr_pkg::lbr_meas_type  last_meas;
    lbr_pkg::lbr_frame_type last_frm;
    logic                   done_seen;
    logic                   terr_seen;
    int                     err_count;
    int                     comparisons;

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    lbr_rx_timing #(.TICK_CYC(TCK)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .rx_line_i(rx_line), .meas_o(meas),
        .frame_o(frm), .busy_o(busy), .stop_run_o(stop_run)
    );
    lbr_bus_ctrl_model #(.TICK_CYC(TCK)) pm_u (
        .clk_sys(clk_sys), .rx_line(rx_line)
    );

    always @(posedge clk_sys) begin
        if (meas.valid === 1'b1) last_meas <= meas;
        if (frm.done === 1'b1) last_frm <= frm;
        if (frm.done === 1'b1) done_seen <= 1'b1;
        if (frm.timing_err === 1'b1) terr_seen <= 1'b1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 2100 * TCK && done_seen !== 1'b1; i++)
            @(posedge clk_sys);
        #1;
        check("done", done_seen, 1'b1);
        if (done_seen !== 1'b1) finish_test();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_frame(input logic [31:0] bits, input int n,
                           input logic sz);
        done_seen = 1'b0;
        pm_u.send_frame(bits, n, HALF);
        wait_done();
        check("size_err", last_frm.size_err, sz);
        if (!sz) check("data", last_frm.data, bits[15:0]);
        $display("frame of %0d bits done", n);
    endtask

    // start fall, low lo; if hi given, high hi then fall ends it
    task automatic probe(input int lo, hi, input logic [1:0] exp);
        logic fin;
        done_seen = 1'b0;
        terr_seen = 1'b0;
        fin = (hi > 0) ? 1'b0 : 1'b1;
        pm_u.level(1'b0, lo);
        if (hi > 0) pm_u.level(1'b1, hi);
        pm_u.level(fin, 4);
        check("width", last_meas.width, (hi > 0) ? hi : lo);
        check("second", last_meas.second, hi > 0);
        check("cls", last_meas.cls, exp);
        check("terr", terr_seen, exp == 2'b00);
        pm_u.level(1'b1, 2100);
        $display("probe %0d %0d done", lo, hi);
    endtask

    initial begin
        rst = 1'b1;
        err_count = 0;
        comparisons = 0;
        done_seen = 1'b0;
        terr_seen = 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        check("busy", busy, 1'b0);
        check("meas", meas, 16'h0000);
        rst = 1'b0;
        pm_u.level(1'b1, 2000);
        t_frame(32'h0000A5C3, 16, 1'b0);
        t_frame(32'h00001234, 15, 1'b1);
        probe(99, 0, 2'b00);
        probe(625, 0, 2'b01);
        probe(626, 0, 2'b00);
        probe(HALF, 580, 2'b01);
        probe(HALF, 1100, 2'b10);
        probe(HALF, 1101, 2'b00);
        finish_test();
    end
endmodule // lbr_rx_timing_test
